// File: logic/capture_compare_timer.sv
// sixteen-bit capture/compare timer with prescaler and port line control
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module capture_compare_timer #(
  parameter int unsigned PRESCALE_WINDOW = timer_pkg::PRESCALE_WINDOW
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_test_mode,
  input wire logic [timer_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_pa_in,
  output logic [7:0] o_pa_out,
  output logic [7:0] o_pa_oe_n,
  output logic o_accum_in,
  output logic o_irq
);
  localparam int CAP_PIN [4] = '{2, 1, 0, 3};
  localparam int CAP_EDGE [4] = '{4, 2, 0, 6};
  localparam logic [timer_pkg::AGE_W-1:0] WIN = PRESCALE_WINDOW[timer_pkg::AGE_W-1:0];

  logic [15:0] cnt_r;
  logic [7:0] lo_buf_r;
  logic [3:0] div_r;
  logic [1:0] psel_r;
  logic psel_lock_r;
  logic [timer_pkg::AGE_W-1:0] age_r;
  logic tick;
  logic tick_d_r;
  logic psel_ok;
  logic cnt_load;
  logic [7:0] flags1_r;
  logic [7:0] mask1_r;
  logic [7:0] act_r;
  logic [7:0] edge_r;
  logic [7:0] acc_r;
  logic [7:0] rd_nxt;
  logic [7:0] set1;
  logic [7:0] oe_n_nxt;
  logic ovf_r;
  logic ovf_en_r;
  logic ovf_set;
  logic [7:3] pmask_r;
  logic [7:3] pdata_r;
  logic [7:3] port_r;
  logic [7:3] port_nxt;
  logic [4:0] force_pend_r;
  logic [4:0] fire;
  logic [15:0] cap_r [3];
  logic [15:0] cmp_val [5];
  logic [4:0] cmp_match;
  logic [3:0] cap_take;
  logic [3:0] cap_inh;
  logic share;
  logic line3_out;
  logic line3_pin;

  // ==========================================================
  // prescaler and free-running counter
  assign tick = (div_r == timer_pkg::div_last(psel_r));
  assign psel_ok = i_test_mode || (!psel_lock_r && age_r < WIN);
  assign cnt_load = i_test_mode && i_wr && i_addr == timer_pkg::A_CNT_HI;
  assign ovf_set = tick && !cnt_load && cnt_r == 16'hFFFF;

  // divider toward the count tick
  always_ff @(posedge i_mclk) begin
    if (i_rst || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 1'h1;
    end
  end

  // prescaler select: outside test mode, one write inside the window after reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      psel_r <= 2'h0;
      psel_lock_r <= 1'h0;
      age_r <= '0;
    end else begin
      if (age_r < WIN) begin
        age_r <= age_r + 1'h1;
      end
      if (i_wr && i_addr == timer_pkg::A_MSK2 && psel_ok) begin
        psel_r <= i_wdata[1:0];
        psel_lock_r <= 1'h1;
      end
    end
  end

  // counter, read-only except the test-mode preset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
      tick_d_r <= 1'h0;
    end else begin
      tick_d_r <= tick;
      if (cnt_load) begin
        cnt_r <= timer_pkg::CNT_TEST_LOAD;
      end else if (tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // lower byte held at the upper-byte read, not reset
  always_ff @(posedge i_mclk) begin
    if (i_rd && i_addr == timer_pkg::A_CNT_HI) begin
      lo_buf_r <= cnt_r[7:0];
    end
  end

  // ==========================================================
  // captures and compares
  assign share = acc_r[timer_pkg::ACC_SHARE];
  assign line3_out = acc_r[timer_pkg::ACC_LINE3_DIR] || act_r[1:0] != 2'h0;
  assign line3_pin = line3_out ? port_r[3] : i_pa_in[3];

  for (genvar i = 0; i < 4; i++) begin : g_cap
    capture_channel u_cap (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_pin(i == 3 ? line3_pin : i_pa_in[CAP_PIN[i]]),
      .i_edge((i == 3 && !share) ? 2'h0 : edge_r[CAP_EDGE[i] +: 2]),
      .o_take(cap_take[i])
    );
    assign cap_inh[i] = i_rd && i_addr == timer_pkg::cap_addr(i);
  end

  for (genvar i = 0; i < 5; i++) begin : g_cmp
    compare_channel u_cmp (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_wr_hi(i_wr && i_addr == timer_pkg::cmp_addr(i) && !(i == 4 && share)),
      .i_wr_lo(i_wr && i_addr == timer_pkg::cmp_addr(i) + 6'h01 && !(i == 4 && share)),
      .i_wdata(i_wdata),
      .i_load(i == 4 && share && cap_take[3] && !cap_inh[3]),
      .i_load_val(cnt_r),
      .i_cnt(cnt_r),
      .i_check(tick_d_r && !(i == 4 && share)),
      .o_value(cmp_val[i]),
      .o_match(cmp_match[i])
    );
    // forced actions align to the count tick
    assign fire[i] = cmp_match[i] || (tick_d_r && force_pend_r[4 - i] && !(i == 4 && share));
  end

  // capture registers, untouched by reset
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (cap_take[i] && !cap_inh[i]) begin
        cap_r[i] <= cnt_r;
      end
    end
  end

  // pending forces, bit 4 is the first compare
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      force_pend_r <= 5'h00;
    end else if (i_wr && i_addr == timer_pkg::A_FORCE) begin
      force_pend_r <= (tick_d_r ? 5'h00 : force_pend_r) | i_wdata[7:3];
    end else if (tick_d_r) begin
      force_pend_r <= 5'h00;
    end
  end

  // ==========================================================
  // control registers and flags
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mask1_r <= 8'h00;
      act_r <= 8'h00;
      edge_r <= 8'h00;
      acc_r <= 8'h00;
      pmask_r <= 5'h00;
      pdata_r <= 5'h00;
      ovf_en_r <= 1'h0;
    end else if (i_wr) begin
      case (i_addr)
        timer_pkg::A_MSK1: mask1_r <= i_wdata;
        timer_pkg::A_ACT: act_r <= i_wdata;
        timer_pkg::A_EDGE: edge_r <= i_wdata;
        timer_pkg::A_ACC: acc_r <= i_wdata & timer_pkg::ACC_WMASK;
        timer_pkg::A_PMASK: pmask_r <= i_wdata[7:3];
        timer_pkg::A_PDATA: pdata_r <= i_wdata[7:3];
        timer_pkg::A_MSK2: ovf_en_r <= i_wdata[timer_pkg::MSK2_OVF];
        default: ;
      endcase
    end
  end

  // flag sources: compares 1..5 then captures 1..3, bit 3 shared
  assign set1 = {cmp_match[0], cmp_match[1], cmp_match[2], cmp_match[3],
                 share ? cap_take[3] : cmp_match[4], cap_take[0], cap_take[1], cap_take[2]};

  // write-one-to-clear, a set in the same cycle wins
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags1_r <= 8'h00;
      ovf_r <= 1'h0;
    end else begin
      flags1_r <= (flags1_r & ~((i_wr && i_addr == timer_pkg::A_FLG1) ? i_wdata : 8'h00)) | set1;
      ovf_r <= (ovf_r && !(i_wr && i_addr == timer_pkg::A_FLG2 && i_wdata[7])) || ovf_set;
    end
  end

  // ==========================================================
  // port line actions
  always_comb begin
    port_nxt = port_r;
    if (i_wr && i_addr == timer_pkg::A_PORT) begin
      port_nxt = i_wdata[7:3];
    end
    for (int k = 1; k < 5; k++) begin
      if (fire[k]) begin
        port_nxt[7 - k] = timer_pkg::pin_action(act_r[9 - 2 * k -: 2], port_r[7 - k]);
      end
    end
    if (fire[0]) begin
      for (int l = 3; l < 8; l++) begin
        if (pmask_r[l]) begin
          port_nxt[l] = pdata_r[l];
        end
      end
    end
  end

  assign oe_n_nxt = {!acc_r[timer_pkg::ACC_LINE7_DIR], 3'h0, !line3_out, 3'h7};
  assign port_r = o_pa_out[7:3];

  // pins, accumulator feed and interrupt request
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pa_out <= 8'h00;
      o_pa_oe_n <= timer_pkg::OE_N_RESET;
      o_accum_in <= 1'h0;
      o_irq <= 1'h0;
    end else begin
      o_pa_out <= {port_nxt, 3'h0};
      o_pa_oe_n <= oe_n_nxt;
      o_accum_in <= (acc_r[timer_pkg::ACC_ENABLE] && acc_r[timer_pkg::ACC_LINE7_DIR]) ? port_nxt[7] : i_pa_in[7];
      o_irq <= (|(flags1_r & mask1_r)) || (ovf_r && ovf_en_r);
    end
  end

  // ==========================================================
  // register read port, data in the following cycle only
  always_comb begin
    rd_nxt = 8'h00;
    case (i_addr)
      timer_pkg::A_PORT: rd_nxt = i_pa_in;
      timer_pkg::A_FORCE: rd_nxt = 8'h00;
      timer_pkg::A_PMASK: rd_nxt = {pmask_r, 3'h0};
      timer_pkg::A_PDATA: rd_nxt = {pdata_r, 3'h0};
      timer_pkg::A_CNT_HI: rd_nxt = cnt_r[15:8];
      timer_pkg::A_CNT_LO: rd_nxt = lo_buf_r;
      timer_pkg::A_ACT: rd_nxt = act_r;
      timer_pkg::A_EDGE: rd_nxt = edge_r;
      timer_pkg::A_MSK1: rd_nxt = mask1_r;
      timer_pkg::A_FLG1: rd_nxt = flags1_r;
      timer_pkg::A_MSK2: rd_nxt = {ovf_en_r, 5'h00, psel_r};
      timer_pkg::A_FLG2: rd_nxt = {ovf_r, 7'h00};
      timer_pkg::A_ACC: rd_nxt = acc_r;
      default: rd_nxt = 8'h00;
    endcase
    for (int i = 0; i < 3; i++) begin
      if (i_addr == timer_pkg::cap_addr(i)) begin
        rd_nxt = cap_r[i][15:8];
      end
      if (i_addr == timer_pkg::cap_addr(i) + 6'h01) begin
        rd_nxt = cap_r[i][7:0];
      end
    end
    for (int i = 0; i < 5; i++) begin
      if (i_addr == timer_pkg::cmp_addr(i)) begin
        rd_nxt = cmp_val[i][15:8];
      end
      if (i_addr == timer_pkg::cmp_addr(i) + 6'h01) begin
        rd_nxt = cmp_val[i][7:0];
      end
    end
  end

  // registered read data
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_nxt : 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  psel_reset_a:
    assert property ($past(i_rst) |-> psel_r == 2'h0) else $error("prescaler not divide-by-one after reset");
  psel_lock_a:
    assert property (psel_lock_r && !i_test_mode ##1 !i_test_mode |-> $stable(psel_r))
      else $error("prescaler changed after lock");
  tick_rate_a:
    assert property (tick && psel_r == 2'h1 ##1 psel_r == 2'h1 [*4]
      |-> tick && $past(!tick) && $past(!tick, 2) && $past(!tick, 3))
      else $error("divide by four tick spacing wrong");
  count_step_a:
    assert property (tick && !cnt_load |=> cnt_r == $past(cnt_r) + 16'h0001) else $error("counter did not step");
  overflow_set_a:
    assert property (tick && !cnt_load && cnt_r == 16'hFFFF |=> ovf_r && cnt_r == 16'h0000)
      else $error("overflow flag not set on roll");
  capture_delay_a:
    assert property ($changed(i_pa_in[2]) && edge_r[5:4] == 2'h3 ##1 !cap_inh[0] && edge_r[5:4] == 2'h3
      |=> cap_r[0] == $past(cnt_r)) else $error("capture value not one cycle after edge");
  capture_block_a:
    assert property (cap_inh[0] |=> $stable(cap_r[0])) else $error("capture changed during upper read");
  compare_flag_a:
    assert property (cmp_match[1] |=> flags1_r[6]) else $error("compare flag not set on match");
  first_wins_a:
    assert property (cmp_match[0] && cmp_match[1] && pmask_r[6] |=> port_r[6] == $past(pdata_r[6]))
      else $error("first compare did not prevail");
  force_noflag_a:
    assert property (tick_d_r && force_pend_r[3] && !cmp_match[1] && !flags1_r[6] |=> !flags1_r[6])
      else $error("forced compare set a flag");
  flag_clear_a:
    assert property (i_wr && i_addr == timer_pkg::A_FLG2 && i_wdata[7] && !ovf_set |=> !ovf_r)
      else $error("overflow flag not cleared by one");
  line3_out_a:
    assert property (act_r[1:0] != 2'h0 |=> !o_pa_oe_n[3]) else $error("line 3 not forced to output");

  overflow_c: cover property (ovf_set);
  capture_c: cover property (cap_take[0] && !cap_inh[0]);
  force_c: cover property (fire[1] && !cmp_match[1]);
  shared_c: cover property (share && cap_take[3]);
endmodule

// File: logic/timer_pkg.sv
// register map, field positions, encodings and counts for the capture/compare timer
// Function
// - one 16-bit counter advances on a prescaled tick: bus clock /1, /4, /8, /16
// - divide by one after reset; outside test mode prescaler written once, only in first 64 cycles
// - upper counter read copies lower byte to buffer; lower read returns it; no reset
// - counter resets to zero, read-only; test-mode upper write loads FFF8
// - roll from FFFF to 0000 sets overflow flag; enable requests interrupt
// - capture latches counter on selected edge; capture registers ignore reset
// - captured value is counter one cycle after the triggering edge
// - selected edge sets capture flag; enable requests interrupt
// - reading capture upper byte blocks captures into it for one cycle
// - reset selects fifth compare; share select makes it a read-only fourth capture
// - with line 3 output and capture enabled, port writes trigger captures
// - nonzero fifth compare action forces line 3 to output
// - five compare registers read/write, reset FFFF, bytes written independently
// - every match sets flag and does pin action; enable requests interrupt
// - compares two to five act on their pin by mode/level pair
// - upper-byte compare write suppresses that compare for one cycle
// - force bits do compare pin actions without flags, aligned to prescaled tick
// - force register is write-only, reads zero; bits 7..3 map compares one to five
// - first compare match drives masked lines 7..3 with its data bits
// - first compare wins over another compare on the same line
// - line 7 output, masked, accumulator on: latch feeds pin and accumulator
// - edge codes: 00 off, 01 rising, 10 falling, 11 both
// - action codes: 00 disconnected, 01 toggle, 10 low, 11 high
// - prescaler codes 00, 01, 10, 11 divide by 1, 4, 8, 16
// - flags clear only when written with one; zero leaves them
package timer_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] A_PORT = 6'h00;
  localparam logic [5:0] A_FORCE = 6'h0B;
  localparam logic [5:0] A_PMASK = 6'h0C;
  localparam logic [5:0] A_PDATA = 6'h0D;
  localparam logic [5:0] A_CNT_HI = 6'h0E;
  localparam logic [5:0] A_CNT_LO = 6'h0F;
  localparam logic [5:0] A_CAP_BASE = 6'h10;
  localparam logic [5:0] A_CMP_BASE = 6'h16;
  localparam logic [5:0] A_ACT = 6'h20;
  localparam logic [5:0] A_EDGE = 6'h21;
  localparam logic [5:0] A_MSK1 = 6'h22;
  localparam logic [5:0] A_FLG1 = 6'h23;
  localparam logic [5:0] A_MSK2 = 6'h24;
  localparam logic [5:0] A_FLG2 = 6'h25;
  localparam logic [5:0] A_ACC = 6'h26;

  // ==========================================================
  // fields and reset values
  localparam int unsigned ACC_LINE7_DIR = 7;
  localparam int unsigned ACC_ENABLE = 6;
  localparam int unsigned ACC_LINE3_DIR = 3;
  localparam int unsigned ACC_SHARE = 2;
  localparam logic [7:0] ACC_WMASK = 8'hCC;
  localparam int unsigned MSK2_OVF = 7;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_TEST_LOAD = 16'hFFF8;
  localparam logic [7:0] OE_N_RESET = 8'h8F;

  // ==========================================================
  // timing counts
  localparam int unsigned PRESCALE_WINDOW = 64;
  localparam int unsigned AGE_W = 7;
  localparam logic [3:0] DIV_LAST_1 = 4'h0;
  localparam logic [3:0] DIV_LAST_4 = 4'h3;
  localparam logic [3:0] DIV_LAST_8 = 4'h7;
  localparam logic [3:0] DIV_LAST_16 = 4'hF;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {ACT_OFF, ACT_TOGGLE, ACT_LOW, ACT_HIGH} action_t;

  // terminal prescaler count per select code
  function automatic logic [3:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h0: div_last = DIV_LAST_1;
      2'h1: div_last = DIV_LAST_4;
      2'h2: div_last = DIV_LAST_8;
      default: div_last = DIV_LAST_16;
    endcase
  endfunction

  // new pin level for an action code
  function automatic logic pin_action(input logic [1:0] act, input logic cur);
    case (action_t'(act))
      ACT_TOGGLE: pin_action = !cur;
      ACT_LOW: pin_action = 1'h0;
      ACT_HIGH: pin_action = 1'h1;
      default: pin_action = cur;
    endcase
  endfunction

  // upper-byte address of capture i (fourth shares the fifth compare)
  function automatic logic [5:0] cap_addr(input int i);
    cap_addr = (i < 3) ? A_CAP_BASE + 6'(2 * i) : A_CMP_BASE + 6'h08;
  endfunction

  // upper-byte address of compare i
  function automatic logic [5:0] cmp_addr(input int i);
    cmp_addr = A_CMP_BASE + 6'(2 * i);
  endfunction

endpackage

// File: logic/capture_channel.sv
// capture edge detector giving a latch pulse one cycle after the edge
`timescale 1ns/1ns
module capture_channel (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [1:0] i_edge,
  output logic o_take
);
  logic prev_r;

  // edge select decode
  function automatic logic edge_hit(input logic [1:0] sel, input logic was, input logic now);
    edge_hit = (sel[0] && !was && now) || (sel[1] && was && !now);
  endfunction

  // previous pin level
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prev_r <= 1'h0;
    end else begin
      prev_r <= i_pin;
    end
  end

  // pulse trails the edge so the counter has moved on by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_take <= 1'h0;
    end else begin
      o_take <= edge_hit(i_edge, prev_r, i_pin);
    end
  end
endmodule

// File: logic/compare_channel.sv
// one compare register with byte writes, write inhibit and match
`timescale 1ns/1ns
module compare_channel (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wr_hi,
  input wire logic i_wr_lo,
  input wire logic [7:0] i_wdata,
  input wire logic i_load,
  input wire logic [15:0] i_load_val,
  input wire logic [15:0] i_cnt,
  input wire logic i_check,
  output logic [15:0] o_value,
  output logic o_match
);
  logic inh_r;

  // byte writes leave the other byte alone; capture load takes all
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_value <= timer_pkg::CMP_RESET;
    end else if (i_load) begin
      o_value <= i_load_val;
    end else if (i_wr_hi) begin
      o_value[15:8] <= i_wdata;
    end else if (i_wr_lo) begin
      o_value[7:0] <= i_wdata;
    end
  end

  // one-cycle inhibit after an upper-byte write
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      inh_r <= 1'h0;
    end else begin
      inh_r <= i_wr_hi;
    end
  end

  assign o_match = i_check && !inh_r && (o_value == i_cnt);
endmodule

// File: test/port_pins.sv
// port pad model for the timer's port lines
`timescale 1ns/1ns
module port_pins (
  input wire logic [7:0] i_pa_out,
  input wire logic [7:0] i_pa_oe_n,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pa_in
);
  // ==========================================================
  // pad resolution
  // a driven line reads back its latch, so port reads return the driven level
  assign o_pa_in = (i_pa_out & ~i_pa_oe_n) | (i_ext & i_pa_oe_n);
endmodule

// File: test/capture_compare_timer_tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
module capture_compare_timer_tb;
  typedef struct {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic i_mclk, i_rst, i_test_mode, i_wr, i_rd, accum, irq;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, ext, pa_in, pa_out, oe_n, rdata, b;
  logic [15:0] v, w;
  int failures, cmp_count;
  row_t rows [9];
  logic [1:0] acts [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
  logic lvls [5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1};

  capture_compare_timer DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_test_mode(i_test_mode), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_pa_in(pa_in), .o_pa_out(pa_out),
    .o_pa_oe_n(oe_n), .o_accum_in(accum), .o_irq(irq));
  port_pins pins (.i_pa_out(pa_out), .i_pa_oe_n(oe_n), .i_ext(ext), .o_pa_in(pa_in));

  // ==========================================================
  // clock and watchdog
  initial begin
    i_mclk = 1'h0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 6'h01, d[7:0]);
  endtask
  // counter advance over a fixed span of cycles
  task automatic rate(input int gap, input int exp);
    rd16(timer_pkg::A_CNT_HI, v);
    repeat (gap - 4) @(posedge i_mclk);
    rd16(timer_pkg::A_CNT_HI, w);
    chk(w - v, 16'(exp));
  endtask
  // set a compare 64 counts ahead
  task automatic arm(input logic [5:0] a);
    rd16(timer_pkg::A_CNT_HI, v);
    v = v + 16'h0040;
    wr(a, v[15:8]);
    wr(a + 6'h01, v[7:0]);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    i_rst = 1'h1;
    i_test_mode = 1'h0;
    i_wr = 1'h0;
    i_rd = 1'h0;
    i_addr = 6'h00;
    i_wdata = 8'h00;
    ext = 8'h00;
    failures = 0;
    cmp_count = 0;
    rows = '{'{1'h1, 6'h18, 8'h12, 8'h12}, '{1'h0, 6'h19, 8'h00, 8'hFF}, '{1'h0, 6'h16, 8'h00, 8'hFF},
      '{1'h0, 6'h1F, 8'h00, 8'hFF}, '{1'h1, 6'h0B, 8'hF8, 8'h00}, '{1'h1, 6'h3F, 8'hAA, 8'h00},
      '{1'h1, 6'h0C, 8'hFF, 8'hF8}, '{1'h1, 6'h0C, 8'h00, 8'h00}, '{1'h0, 6'h23, 8'h00, 8'h00}};
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'h0;
    #1 chk(16'(oe_n), 16'(timer_pkg::OE_N_RESET));
    rate(8, 8);
    wr(timer_pkg::A_MSK2, 8'h81);
    rate(64, 16);
    wr(timer_pkg::A_MSK2, 8'h83);
    rate(64, 16);
    // register table rows
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a, b);
      chk(16'(b), 16'(rows[i].e));
    end
    // test-mode preset, overflow flag and its clearing
    i_test_mode <= 1'h1;
    wr(timer_pkg::A_MSK2, 8'h80);
    wr(timer_pkg::A_CNT_HI, 8'h00);
    rd(timer_pkg::A_CNT_HI, b);
    chk(16'(b), 16'h00FF);
    i_test_mode <= 1'h0;
    repeat (12) @(posedge i_mclk);
    rd(timer_pkg::A_FLG2, b);
    chk(16'(b), 16'h0080);
    chk(16'(irq), 16'h0001);
    wr(timer_pkg::A_FLG2, 8'h00);
    rd(timer_pkg::A_FLG2, b);
    chk(16'(b), 16'h0080);
    wr(timer_pkg::A_FLG2, 8'h80);
    rd(timer_pkg::A_FLG2, b);
    chk(16'(b), 16'h0000);
    chk(16'(irq), 16'h0000);
    // every action code on compare two, line 6
    foreach (acts[i]) begin
      wr(timer_pkg::A_ACT, {acts[i], 6'h00});
      arm(6'h18);
      repeat (80) @(posedge i_mclk);
      chk(16'(pa_out[6]), 16'(lvls[i]));
      rd(timer_pkg::A_FLG1, b);
      chk(16'(b & 8'h40), 16'h0040);
      wr(timer_pkg::A_FLG1, 8'h40);
    end
    // first compare beats compare two on line 6 and feeds the accumulator
    wr(timer_pkg::A_ACC, 8'hC0);
    wr(timer_pkg::A_PMASK, 8'hC0);
    wr(timer_pkg::A_PDATA, 8'h80);
    wr(timer_pkg::A_ACT, 8'hC0);
    arm(6'h16);
    wr(6'h18, v[15:8]);
    wr(6'h19, v[7:0]);
    repeat (80) @(posedge i_mclk);
    chk(16'(pa_out[7:6]), 16'h0002);
    chk(16'(accum), 16'h0001);
    chk(16'(oe_n[7]), 16'h0000);
    // forced compare with the drive-high action, never toggle
    wr(timer_pkg::A_FLG1, 8'hF8);
    wr(timer_pkg::A_FORCE, 8'h40);
    repeat (20) @(posedge i_mclk);
    chk(16'(pa_out[6]), 16'h0001);
    rd(timer_pkg::A_FLG1, b);
    chk(16'(b & 8'h40), 16'h0000);
    // capture value is the counter one cycle after the edge
    wr(timer_pkg::A_EDGE, 8'h10);
    @(posedge i_mclk);
    i_rd <= 1'h1;
    i_addr <= timer_pkg::A_CNT_HI;
    ext[2] <= 1'h1;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1 v[15:8] = rdata;
    rd(timer_pkg::A_CNT_LO, v[7:0]);
    rd16(6'h10, w);
    chk(w, v + 16'h0001);
    // each edge code against a fall and a rise
    wr(timer_pkg::A_MSK1, 8'h04);
    for (int c = 0; c < 4; c++) begin
      wr(timer_pkg::A_EDGE, 8'(c << 4));
      wr(timer_pkg::A_FLG1, 8'h04);
      ext[2] <= 1'h0;
      repeat (3) @(posedge i_mclk);
      rd(timer_pkg::A_FLG1, b);
      chk(16'(b[2]), 16'(c[1]));
      wr(timer_pkg::A_FLG1, 8'h04);
      ext[2] <= 1'h1;
      repeat (3) @(posedge i_mclk);
      rd(timer_pkg::A_FLG1, b);
      chk(16'(b[2]), 16'(c[0]));
      chk(16'(irq), 16'(c[0]));
    end
    // fifth compare action takes line 3; shared register refuses writes
    wr(timer_pkg::A_ACT, 8'h01);
    @(posedge i_mclk);
    #1 chk(16'(oe_n[3]), 16'h0000);
    wr(timer_pkg::A_ACT, 8'h00);
    wr(timer_pkg::A_ACC, 8'h04);
    wr(6'h1E, 8'h55);
    rd(6'h1E, b);
    chk(16'(b), 16'h00FF);
    // port writes on output line 3 make fourth-capture edges
    wr(timer_pkg::A_ACC, 8'h0C);
    wr(timer_pkg::A_EDGE, 8'h40);
    wr(timer_pkg::A_PORT, 8'h08);
    rd16(timer_pkg::A_CNT_HI, v);
    rd16(6'h1E, w);
    chk(w, v);
    rd(timer_pkg::A_FLG1, b);
    chk(16'(b & 8'h08), 16'h0008);
    // second reset in mid-run
    @(posedge i_mclk);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_mclk);
    #1 chk(16'(pa_out), 16'h0000);
    chk(16'(oe_n), 16'(timer_pkg::OE_N_RESET));
    @(posedge i_mclk);
    i_rst <= 1'h0;
    rd(6'h18, b);
    chk(16'(b), 16'h00FF);
    rate(8, 8);
    // prescaler write refused once the window after reset has run out
    repeat (64) @(posedge i_mclk);
    wr(timer_pkg::A_MSK2, 8'h03);
    rate(8, 8);
    tally_and_finish();
  end
endmodule
